//--- dbsp_top.sv
// pin-level read and write ports of the double data rate burst sram
// Notes on behaviour
// RQ1 - write data captured on both input clock edges
// RQ2 - low write select at k starts write
// RQ3 - high write select ignores write data
// RQ4 - byte selects sampled with their data word
// RQ5 - each byte select covers one nine-bit lane
// RQ6 - deselected bytes stay unchanged in array
// RQ7 - shared address sampled at k rising edge
// RQ8 - 19-bit burst address, four words each
// RQ9 - address ignored when its port unselected
// RQ10 - read words launched on both clock edges
// RQ11 - read outputs float when port deselected
// RQ12 - low read select at k starts read
// RQ13 - finish burst, float after next k edge
// RQ14 - each read returns four sequential words
// RQ15 - valid flag marks data, aligned to echo
// RQ16 - accesses start only at k rising edge
// RQ17 - k_n edge captures inputs, launches data
// RQ18 - free-running echo clock pair follows k
// RQ19 - pll disable selects one-cycle read latency
// RQ20 - pll on: data two and half cycles
// RQ21 - controller sends write words on four edges
`timescale 1ns/1ps
`default_nettype none
module dbsp_top
  import dbsp_pkg::*;
#(
  parameter int AW = ADDR_WIDTH,
  parameter int DW = DATA_WIDTH,
  parameter int LANES = BYTE_LANES,
  parameter int LANE_W = BYTE_WIDTH
) (
  // system clock and reset
  input wire logic clock,
  input wire logic rstn,
  // input clock pair from the controller
  input wire logic k,
  input wire logic k_n,
  // mode strap
  input wire logic pll_disable_n,
  // write port
  input wire logic write_port_select_n,
  input wire logic [LANES-1:0] byte_write_select_n,
  input wire logic [DW-1:0] write_data,
  // shared address
  input wire logic [AW-1:0] address,
  // read port
  input wire logic read_port_select_n,
  output logic [DW-1:0] read_data,
  output logic read_data_oe,
  output logic read_valid_flag,
  // echo clock pair
  output logic echo_clock,
  output logic echo_clock_n
);

  localparam int SYNC_W = 5 + LANES + DW + AW;
  localparam int MEM_AW = AW + BEAT_W;

  // word address inside the array for one beat of a burst
  function automatic logic [MEM_AW-1:0] burst_addr(input logic [AW-1:0] base,
                                                   input logic [BEAT_W-1:0] beat);
    burst_addr = {base, beat};
  endfunction

  // synchronised pins
  logic k_s;
  logic k_n_s;
  logic wps_n_s;
  logic rps_n_s;
  logic pll_dis_n_s;
  logic [LANES-1:0] bws_n_s;
  logic [DW-1:0] wdata_s;
  logic [AW-1:0] addr_s;

  // data and control pass the same two stages, so they stay aligned to the clock edges
  dbsp_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in({k, k_n, write_port_select_n, read_port_select_n, pll_disable_n,
               byte_write_select_n, write_data, address}),
    .sync_out({k_s, k_n_s, wps_n_s, rps_n_s, pll_dis_n_s, bws_n_s, wdata_s, addr_s})
  );

  // edge finding on the input clock pair
  logic k_prev_q;
  logic k_prev_d;
  logic k_n_prev_q;
  logic k_n_prev_d;
  logic k_rise;
  logic k_n_rise;
  logic half_edge;

  always_comb
  begin
    k_prev_d = k_s;
    k_n_prev_d = k_n_s;
    k_rise = k_s & ~k_prev_q;
    // k has priority should both edges land in one system cycle
    k_n_rise = k_n_s & ~k_n_prev_q & ~k_rise;
    half_edge = k_rise | k_n_rise;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      k_prev_q <= 1'h0;
      k_n_prev_q <= 1'h0;
    end
    else
    begin
      k_prev_q <= k_prev_d;
      k_n_prev_q <= k_n_prev_d;
    end
  end

  // write port
  dbsp_wr_state_t wr_state_q;
  dbsp_wr_state_t wr_state_d;
  logic wr_arm_q;
  logic wr_arm_d;
  logic [AW-1:0] wr_arm_addr_q;
  logic [AW-1:0] wr_arm_addr_d;
  logic [AW-1:0] wr_addr_q;
  logic [AW-1:0] wr_addr_d;
  logic wr_block_q;
  logic wr_block_d;
  logic wr_word;
  logic [BEAT_W-1:0] wr_beat;
  logic [LANES-1:0] mem_we;
  logic [MEM_AW-1:0] mem_waddr;

  always_comb
  begin
    wr_state_d = wr_state_q;
    wr_arm_d = wr_arm_q;
    wr_arm_addr_d = wr_arm_addr_q;
    wr_addr_d = wr_addr_q;
    wr_block_d = wr_block_q;
    wr_word = 1'h0;
    wr_beat = 2'h0;
    if (k_rise)
    begin
      // a burst spans two k cycles, so the select is not looked at on the edge after one
      wr_arm_d = ~wps_n_s & ~wr_block_q; // see RQ2, see RQ16
      wr_block_d = wr_arm_d;
      if (wr_arm_d)
      begin
        wr_arm_addr_d = addr_s; // see RQ7, see RQ9
      end
      case (wr_state_q)
        WR_BEAT2:
        begin
          wr_word = 1'h1;
          wr_beat = 2'h2;
          wr_state_d = WR_BEAT3;
        end
        WR_IDLE, WR_BEAT1, WR_BEAT3:
        begin
          if (wr_arm_q)
          begin
            // first word comes on the k edge after the request
            wr_word = 1'h1;
            wr_beat = 2'h0;
            wr_addr_d = wr_arm_addr_q;
            wr_state_d = WR_BEAT1; // see RQ21
          end
          else
          begin
            wr_state_d = WR_IDLE;
          end
        end
        default:
        begin
          wr_state_d = WR_IDLE;
        end
      endcase
    end
    else if (k_n_rise)
    begin
      case (wr_state_q)
        WR_BEAT1:
        begin
          wr_word = 1'h1; // see RQ17
          wr_beat = 2'h1;
          wr_state_d = WR_BEAT2;
        end
        WR_BEAT3:
        begin
          wr_word = 1'h1;
          wr_beat = 2'h3;
          wr_state_d = WR_IDLE;
        end
        default:
        begin
          wr_state_d = wr_state_q;
        end
      endcase
    end
    // outside a burst the data pins are never looked at
    mem_we = wr_word ? ~bws_n_s : '0; // see RQ1, see RQ3, see RQ4, see RQ6
    mem_waddr = burst_addr((wr_state_q == WR_BEAT1 || wr_state_q == WR_BEAT2 ||
                            wr_state_q == WR_BEAT3) ? wr_addr_q : wr_arm_addr_q, wr_beat);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_state_q <= WR_IDLE;
      wr_arm_q <= 1'h0;
      wr_arm_addr_q <= '0;
      wr_addr_q <= '0;
      wr_block_q <= 1'h0;
    end
    else
    begin
      wr_state_q <= wr_state_d;
      wr_arm_q <= wr_arm_d;
      wr_arm_addr_q <= wr_arm_addr_d;
      wr_addr_q <= wr_addr_d;
      wr_block_q <= wr_block_d;
    end
  end

  // read request pipeline, one stage per half cycle of the input clock
  logic [RD_STAGES-1:0] tok_v_q;
  logic [RD_STAGES-1:0] tok_v_d;
  logic [AW-1:0] tok_a_q [RD_STAGES];
  logic [AW-1:0] tok_a_d [RD_STAGES];
  logic rd_block_q;
  logic rd_block_d;
  logic rd_accept;
  logic emerge;
  logic [AW-1:0] emerge_addr;
  int unsigned ins;

  always_comb
  begin
    tok_v_d = tok_v_q;
    tok_a_d = tok_a_q;
    rd_block_d = rd_block_q;
    emerge = 1'h0;
    emerge_addr = tok_a_q[RD_STAGES-1];
    rd_accept = 1'h0;
    // latency is chosen per request from the current strap level
    ins = pll_dis_n_s ? 32'(RD_STAGES - RD_LAT_PLL_ON) : 32'(RD_STAGES - RD_LAT_PLL_OFF); // see RQ19, see RQ20
    if (half_edge)
    begin
      emerge = tok_v_q[RD_STAGES-1];
      for (int i = RD_STAGES - 1; i > 0; i--)
      begin
        tok_v_d[i] = tok_v_q[i-1];
        tok_a_d[i] = tok_a_q[i-1];
      end
      tok_v_d[0] = 1'h0;
    end
    if (k_rise)
    begin
      rd_accept = ~rps_n_s & ~rd_block_q; // see RQ12, see RQ16
      rd_block_d = rd_accept;
      if (rd_accept)
      begin
        tok_v_d[ins] = 1'h1;
        tok_a_d[ins] = addr_s; // see RQ7, see RQ9
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tok_v_q <= '0;
      rd_block_q <= 1'h0;
      for (int i = 0; i < RD_STAGES; i++)
      begin
        tok_a_q[i] <= '0;
      end
    end
    else
    begin
      tok_v_q <= tok_v_d;
      tok_a_q <= tok_a_d;
      rd_block_q <= rd_block_d;
    end
  end

  // read burst sequencer
  dbsp_rd_state_t rd_state_q;
  dbsp_rd_state_t rd_state_d;
  logic [AW-1:0] rd_addr_q;
  logic [AW-1:0] rd_addr_d;
  logic launch;
  logic [BEAT_W-1:0] rd_beat;
  logic [MEM_AW-1:0] mem_raddr;

  always_comb
  begin
    rd_state_d = rd_state_q;
    rd_addr_d = rd_addr_q;
    launch = 1'h0;
    rd_beat = 2'h0;
    if (half_edge)
    begin
      case (rd_state_q)
        RD_IDLE:
        begin
          if (emerge)
          begin
            launch = 1'h1;
            rd_addr_d = emerge_addr;
            rd_state_d = RD_BEAT1;
          end
        end
        RD_BEAT1:
        begin
          launch = 1'h1;
          rd_beat = 2'h1;
          rd_state_d = RD_BEAT2;
        end
        RD_BEAT2:
        begin
          launch = 1'h1;
          rd_beat = 2'h2;
          rd_state_d = RD_BEAT3;
        end
        RD_BEAT3:
        begin
          launch = 1'h1; // see RQ14
          rd_beat = 2'h3;
          rd_state_d = RD_IDLE;
        end
        default:
        begin
          rd_state_d = RD_IDLE;
        end
      endcase
    end
    mem_raddr = burst_addr(rd_addr_d, rd_beat);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_state_q <= RD_IDLE;
      rd_addr_q <= '0;
    end
    else
    begin
      rd_state_q <= rd_state_d;
      rd_addr_q <= rd_addr_d;
    end
  end

  logic [DW-1:0] mem_rdata;

  dbsp_mem #(
    .AW(MEM_AW),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_mem (
    .clock(clock),
    .rstn(rstn),
    .we(mem_we), // see RQ5
    .waddr(mem_waddr),
    .wdata(wdata_s),
    .raddr(mem_raddr), // see RQ8
    .rdata(mem_rdata)
  );

  // output stage: memory read costs one cycle, so edge markers wait one cycle too
  logic launch_q;
  logic edge_k_q;
  logic edge_any_q;
  logic echo_p_q;
  logic [DW-1:0] read_data_q;
  logic [DW-1:0] read_data_d;
  logic read_data_oe_q;
  logic read_data_oe_d;
  logic read_valid_flag_q;
  logic read_valid_flag_d;
  logic echo_clock_q;
  logic echo_clock_n_q;

  always_comb
  begin
    read_data_d = read_data_q;
    read_data_oe_d = read_data_oe_q;
    read_valid_flag_d = read_valid_flag_q;
    if (launch_q)
    begin
      read_data_d = mem_rdata; // see RQ10, see RQ17
      read_data_oe_d = 1'h1;
      read_valid_flag_d = 1'h1; // see RQ15
    end
    else if (edge_any_q)
    begin
      read_valid_flag_d = 1'h0;
      if (edge_k_q)
      begin
        // drivers float only on a k edge with no word, so a running burst always ends
        read_data_oe_d = 1'h0; // see RQ11, see RQ13
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      launch_q <= 1'h0;
      edge_k_q <= 1'h0;
      edge_any_q <= 1'h0;
      echo_p_q <= ECHO_RST;
      read_data_q <= READ_DATA_RST;
      read_data_oe_q <= 1'h0;
      read_valid_flag_q <= 1'h0;
      echo_clock_q <= ECHO_RST;
      echo_clock_n_q <= ~ECHO_RST;
    end
    else
    begin
      launch_q <= launch;
      edge_k_q <= k_rise;
      edge_any_q <= half_edge;
      // two stages match the data path so echo edges line up with data
      echo_p_q <= k_s;
      read_data_q <= read_data_d;
      read_data_oe_q <= read_data_oe_d;
      read_valid_flag_q <= read_valid_flag_d;
      echo_clock_q <= echo_p_q; // see RQ18, see RQ15
      echo_clock_n_q <= ~echo_p_q;
    end
  end

  assign read_data = read_data_q;
  assign read_data_oe = read_data_oe_q;
  assign read_valid_flag = read_valid_flag_q;
  assign echo_clock = echo_clock_q;
  assign echo_clock_n = echo_clock_n_q;

endmodule // dbsp_top
`default_nettype wire

//--- dbsp_pkg.sv
// shared constants and state types for the burst sram port logic
package dbsp_pkg;

  // array geometry
  localparam int DATA_WIDTH = 36;
  localparam int BYTE_WIDTH = 9;
  localparam int BYTE_LANES = 4;
  localparam int ADDR_WIDTH = 19;
  localparam int BURST_LEN = 4;
  localparam int BEAT_W = 2;

  // read latency in half cycles of the input clock pair
  localparam int RD_STAGES = 5;
  localparam int RD_LAT_PLL_ON = 5;
  localparam int RD_LAT_PLL_OFF = 2;

  // pll-off operation is only specified up to this input rate
  localparam int PLL_OFF_MAX_MHZ = 167;
  localparam int CLOCK_MHZ = 200;

  // reset values
  localparam logic [DATA_WIDTH-1:0] READ_DATA_RST = 36'h0;
  localparam logic ECHO_RST = 1'h0;

  typedef enum logic [3:0] {
    WR_IDLE = 4'h1,
    WR_BEAT1 = 4'h2,
    WR_BEAT2 = 4'h4,
    WR_BEAT3 = 4'h8
  } dbsp_wr_state_t;

  typedef enum logic [3:0] {
    RD_IDLE = 4'h1,
    RD_BEAT1 = 4'h2,
    RD_BEAT2 = 4'h4,
    RD_BEAT3 = 4'h8
  } dbsp_rd_state_t;

endpackage

//--- dbsp_sync.sv
// two flip-flop synchroniser for pins arriving from the link side
`timescale 1ns/1ps
`default_nettype none
module dbsp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // pins in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // meta_q is read by sync_q only
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // dbsp_sync
`default_nettype wire

//--- dbsp_mem.sv
// burst array with per-lane write enables and a registered read port
`timescale 1ns/1ps
`default_nettype none
module dbsp_mem #(
  parameter int AW = 21,
  parameter int LANES = 4,
  parameter int LANE_W = 9
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // write port
  input wire logic [LANES-1:0] we,
  input wire logic [AW-1:0] waddr,
  input wire logic [LANES*LANE_W-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [LANES*LANE_W-1:0] rdata
);

  logic [LANES*LANE_W-1:0] mem [0:(1<<AW)-1];
  logic [LANES*LANE_W-1:0] rdata_q;

  // lanes left disabled keep their stored contents
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (we[i])
      begin
        mem[waddr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= mem[raddr];
    end
  end

  assign rdata = rdata_q;

endmodule // dbsp_mem
`default_nettype wire

//--- dbsp_checker_assertions.sv
// concurrent checks on the burst sram pins
`timescale 1ns/1ps
`default_nettype none
module dbsp_checker
  import dbsp_pkg::*;
#(
  parameter int AW = ADDR_WIDTH,
  parameter int DW = DATA_WIDTH,
  parameter int LANES = BYTE_LANES,
  parameter int LANE_W = BYTE_WIDTH
) (
  // system clock and reset
  input wire logic clock,
  input wire logic rstn,
  // controller side pins
  input wire logic k,
  input wire logic k_n,
  input wire logic pll_disable_n,
  input wire logic write_port_select_n,
  input wire logic [LANES-1:0] byte_write_select_n,
  input wire logic [DW-1:0] write_data,
  input wire logic [AW-1:0] address,
  input wire logic read_port_select_n,
  // read side pins
  input wire logic [DW-1:0] read_data,
  input wire logic read_data_oe,
  input wire logic read_valid_flag,
  input wire logic echo_clock,
  input wire logic echo_clock_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // words in the current valid run, counted on echo edges
  // wide enough for a long run of back to back bursts
  logic echo_q;
  logic [7:0] words_q;
  logic [7:0] words_d;
  always_comb
  begin
    words_d = words_q;
    if (!read_valid_flag)
      words_d = 8'h0;
    else if (echo_clock != echo_q)
      words_d = words_q + 8'h1;
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      echo_q <= 1'h0;
      words_q <= 8'h0;
    end
    else
    begin
      echo_q <= echo_clock;
      words_q <= words_d;
    end
  end
  chk_echo_pair: assert property (echo_clock_n == !echo_clock)
    else $error("echo pair not complementary");
  chk_echo_rise: assert property ($rose(k) |-> ##[2:7] $rose(echo_clock))
    else $error("echo clock missed a rising input clock");
  chk_echo_fall: assert property ($fell(k) |-> ##[2:7] $fell(echo_clock))
    else $error("echo clock missed a falling input clock");
  chk_valid_align: assert property ($changed(read_valid_flag) |-> $changed(echo_clock))
    else $error("valid flag moved off an echo edge");
  chk_data_align: assert property (read_valid_flag && $changed(read_data)
    |-> $changed(echo_clock))
    else $error("read word launched off an echo edge");
  chk_valid_oe: assert property (read_valid_flag |-> read_data_oe)
    else $error("valid data while outputs float");
  chk_oe_rise: assert property ($rose(read_data_oe) |-> read_valid_flag)
    else $error("outputs driven without a word");
  chk_burst_len: assert property ($fell(read_valid_flag)
    |-> words_q[1:0] == 2'h0 && words_q != 8'h0)
    else $error("valid run not a whole number of bursts");
  chk_oe_drop: assert property ($fell(read_valid_flag) |-> ##[0:10] !read_data_oe)
    else $error("outputs not floated after burst");
endmodule // dbsp_checker

bind dbsp_top dbsp_checker #(.AW(AW), .DW(DW), .LANES(LANES), .LANE_W(LANE_W)) i_chk (
  .clock, .rstn, .k, .k_n, .pll_disable_n, .write_port_select_n, .byte_write_select_n,
  .write_data, .address, .read_port_select_n, .read_data, .read_data_oe,
  .read_valid_flag, .echo_clock, .echo_clock_n);
`default_nettype wire

//--- dbsp_ctrl_model.sv
// memory controller model playing one slot of pin values per input clock edge
`timescale 1ns/1ps
`default_nettype none
module dbsp_ctrl_model
  import dbsp_pkg::*;
#(
  parameter int AW = 4,
  parameter int NS = 160
) (
  // system clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic run,
  // pins toward the sram
  output logic k,
  output logic k_n,
  output logic pll_disable_n,
  output logic write_port_select_n,
  output logic [BYTE_LANES-1:0] byte_write_select_n,
  output logic [DATA_WIDTH-1:0] write_data,
  output logic [AW-1:0] address,
  output logic read_port_select_n
);
  typedef struct packed {
    logic wsel_n;
    logic rsel_n;
    logic pll_n;
    logic [BYTE_LANES-1:0] bm;
    logic [DATA_WIDTH-1:0] wd;
    logic [AW-1:0] ad;
  } dbsp_slot_t;
  // even slots meet k rises, odd slots k_n rises
  dbsp_slot_t slot [NS];
  int ph;
  int e;
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      k <= 1'h0;
      k_n <= 1'h1;
      ph <= 1;
      e <= 0;
      {write_port_select_n, read_port_select_n, pll_disable_n} <= 3'h7;
      byte_write_select_n <= 4'hF;
      write_data <= '0;
      address <= '0;
    end
    else if (run && e < NS)
    begin
      ph <= (ph + 1) % 8;
      // pins move midway between edges so the sampler sees them settled
      if (ph == 4)
        {write_port_select_n, read_port_select_n, pll_disable_n, byte_write_select_n,
          write_data, address} <= slot[e];
      if (ph == 0)
      begin
        k <= ~k;
        k_n <= k;
        e <= e + 1;
      end
    end
  end
endmodule // dbsp_ctrl_model
`default_nettype wire

//--- testbench.sv
// self-checking bench for the burst sram ports
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import dbsp_pkg::*;
  localparam int AW = 4;
  localparam int NS = 160;
  typedef struct packed {
    int at;
    logic [DATA_WIDTH-1:0] d;
  } dbsp_note_t;
  logic clock, rstn, run, k, k_n, pll_disable_n, write_port_select_n, read_port_select_n;
  logic [BYTE_LANES-1:0] byte_write_select_n;
  logic [DATA_WIDTH-1:0] write_data, read_data;
  logic [AW-1:0] address;
  logic read_data_oe, read_valid_flag, echo_clock, echo_clock_n, exp_v;
  logic echo_q = 1'h0;
  logic [31:0] r;
  logic [31:0] seed = 32'h5A71;
  logic [DATA_WIDTH-1:0] shadow [2**(AW+2)];
  dbsp_note_t notes[$];
  int fail_count = 0;
  int samples_checked = 0;
  int jcnt = 0;
  // echo edge of the latest word; outputs must float two edges later
  int lastw = -9;

  dbsp_top #(.AW(AW)) i_dut (.clock, .rstn, .k, .k_n, .pll_disable_n, .write_port_select_n,
    .byte_write_select_n, .write_data, .address, .read_port_select_n, .read_data,
    .read_data_oe, .read_valid_flag, .echo_clock, .echo_clock_n);
  dbsp_ctrl_model #(.AW(AW), .NS(NS)) i_ctrl (.clock, .rstn, .run, .k, .k_n, .pll_disable_n,
    .write_port_select_n, .byte_write_select_n, .write_data, .address, .read_port_select_n);

  always #2.5 clock = ~clock;

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wr(input int e, input int a, input bit masked);
    logic [BYTE_LANES-1:0] m;
    logic [DATA_WIDTH-1:0] w;
    i_ctrl.slot[e].wsel_n = 1'h0;
    i_ctrl.slot[e].ad = AW'(a);
    for (int b = 0; b < BURST_LEN; b++)
    begin
      w = DATA_WIDTH'({rnd(), rnd()});
      m = masked ? BYTE_LANES'(rnd()) : '0;
      i_ctrl.slot[e+2+b].wd = w;
      i_ctrl.slot[e+2+b].bm = m;
      for (int l = 0; l < BYTE_LANES; l++)
        if (!m[l])
          shadow[a*4+b][l*BYTE_WIDTH+:BYTE_WIDTH] = w[l*BYTE_WIDTH+:BYTE_WIDTH];
    end
  endtask

  task automatic rd(input int e, input int a);
    dbsp_note_t n;
    i_ctrl.slot[e].rsel_n = 1'h0;
    i_ctrl.slot[e].ad = AW'(a);
    for (int b = 0; b < BURST_LEN; b++)
    begin
      n.at = e + b + (i_ctrl.slot[e].pll_n ? 5 : 2);
      n.d = shadow[a*4+b];
      notes.push_back(n);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // every echo edge: a word is due exactly when the oldest note names this edge
  always @(negedge clock)
  begin
    if (rstn && echo_clock !== echo_q)
    begin
      exp_v = notes.size() > 0 && notes[0].at == jcnt;
      `CHECK("valid", exp_v, read_valid_flag)
      if (exp_v)
      begin
        `CHECK("read word", notes[0].d, read_data)
        `CHECK("output enable", 1'h1, read_data_oe)
        lastw = jcnt;
        void'(notes.pop_front());
      end
      else if (jcnt >= lastw + 2)
      begin
        `CHECK("output float", 1'h0, read_data_oe)
      end
      jcnt++;
    end
    echo_q = echo_clock;
  end

  initial
  begin
    clock = 1'h0;
    rstn = 1'h0;
    run = 1'h0;
    // idle pins carry noise; selects toggle randomly on k_n slots only
    for (int i = 0; i < NS; i++)
    begin
      r = rnd();
      i_ctrl.slot[i] = {i[0] ? r[1:0] : 2'h3, 1'(i < 120), r[7:4],
        DATA_WIDTH'({rnd(), r}), AW'(r[31:8])};
    end
    wr(4, 0, 0);
    i_ctrl.slot[6].wsel_n = 1'h0;
    wr(8, 1, 0);
    wr(12, 2, 0);
    wr(16, 3, 0);
    wr(24, 0, 1);
    wr(28, 1, 1);
    rd(40, 0);
    i_ctrl.slot[42].rsel_n = 1'h0;
    rd(44, 1);
    rd(48, 2);
    rd(52, 3);
    wr(64, 2, 1);
    rd(66, 3);
    rd(124, 2);
    rd(128, 0);
    wr(132, 1, 0);
    rd(144, 1);
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    repeat (3) @(posedge clock);
    run <= 1'h1;
    for (int t = 0; t < 3000 && i_ctrl.e < NS; t++)
      @(posedge clock);
    repeat (80) @(posedge clock);
    `CHECK("slots played", 1'h1, 1'(i_ctrl.e == NS))
    `CHECK("words left", 0, notes.size())
    complete_run();
  end
endmodule // testbench
`default_nettype wire
